// File: verilog/sdlc_top.sv
/*
 * Digital front end of a 12-bit converter: serial input register, converter
 * register, load strobe and clear, all sampled by the local 50 MHz clock.
 * Assumes link pins change no faster than every few clock periods.
 */
`timescale 1ns/1ps
// Contract
// - With select low, clear and load high, shift clock rising edge shifts data in.
// - Most significant bit arrives first and ends at the top of the word.
// - Both registers hold one 12-bit code.
// - Select is active low; when high, shift clock does nothing.
// - Select rising while shift clock low also shifts one bit.
// - Load strobe falling with select and clear high copies shift register.
// - Converter register follows shift register while load strobe is low.
// - Clear low zeroes the converter register, which keeps zero afterwards while load strobe stays high.
// - Shift register is separate, so preloading leaves the output alone.
module sdlc_top (
    // Clock and reset.
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    // Serial link pins.
    input  wire logic        i_shift_clock,
    input  wire logic        i_serial_data_in,
    input  wire logic        i_select_n,
    // Control pins.
    input  wire logic        i_load_strobe_n,
    input  wire logic        i_clear_n,
    // Converter code and shift register view.
    output logic      [11:0] o_code,
    output logic      [11:0] o_shift_word
);
    // Synchronised pins, their previous samples and the next converter code.
    logic [2:0]  link_sync;
    logic [1:0]  ctrl_sync;
    logic        shift_clock_prev;
    logic        select_n_prev;
    logic        load_n_prev;
    logic [11:0] next_code;

    // Synchronised pin levels by name.
    wire sclk_s   = link_sync[2];
    wire data_s   = link_sync[1];
    wire sel_n_s  = link_sync[0];
    wire load_n_s = ctrl_sync[1];
    wire clear_n_s = ctrl_sync[0];

    // Link pins pass two flip-flops before any logic reads them.
    sdlc_sync #(.WIDTH(3), .RESET_VALUE(sdlc_pkg::PIN_RESET)) u_link_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   ({i_shift_clock, i_serial_data_in, i_select_n}),
        .o_sync    (link_sync)
    );
    sdlc_sync #(.WIDTH(2), .RESET_VALUE(sdlc_pkg::CTRL_RESET)) u_ctrl_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   ({i_load_strobe_n, i_clear_n}),
        .o_sync    (ctrl_sync)
    );

    // Rising-edge test on a synchronised level and its previous sample.
    // Edges are found on sampled levels, so each pin level must stand three clocks or more.
    function automatic logic sdlc_rise(input logic now_level, input logic last_level);
        return now_level & ~last_level;
    endfunction

    // Edge decode; select and shift clock act as one gated clock.
    wire sclk_rise  = sdlc_rise(sclk_s, shift_clock_prev);
    wire sel_rise   = sdlc_rise(sel_n_s, select_n_prev);
    wire gate_ok    = clear_n_s & load_n_s;
    wire shift_edge = gate_ok & ((sclk_rise & ~sel_n_s)
                    | (sel_rise & ~sclk_s & ~shift_clock_prev));
    wire load_fall  = sdlc_rise(load_n_prev, load_n_s);
    // A falling edge copies only with select high; the low level after it copies always.
    wire load_act   = ~load_n_s & (sel_n_s | ~load_fall);

    // Clear has priority, then the strobe; otherwise hold.
    assign next_code = !clear_n_s ? sdlc_pkg::CODE_ZERO
                     : load_act   ? o_shift_word
                     : o_code;

    // Edge history of the synchronised pins.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift_clock_prev <= 1'b1;
            select_n_prev    <= 1'b1;
            load_n_prev      <= 1'b1;
        end else begin
            shift_clock_prev <= sclk_s;
            select_n_prev    <= sel_n_s;
            load_n_prev      <= load_n_s;
        end
    end

    // Shift register: MSB first, older bits fall off the top.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_shift_word <= sdlc_pkg::CODE_RESET;
        end else if (shift_edge) begin
            o_shift_word <= {o_shift_word[10:0], data_s};
        end
    end

    // Converter register.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_code <= sdlc_pkg::CODE_RESET;
        end else begin
            o_code <= next_code;
        end
    end

    // Checks on the synchronised pins; the async reset disables them all.
    // The oldest bit leaves at the top, so only the last twelve remain.
    property p_top_bit;
        @(posedge i_clock) disable iff (!i_reset_n)
        shift_edge |=> o_shift_word[11] == $past(o_shift_word[10]);
    endproperty
    a_top_bit: assert property (p_top_bit) else $error("Top bit not discarded.");

    // With no edge decoded the serial input register must not move at all.
    property p_stray;
        @(posedge i_clock) disable iff (!i_reset_n)
        !shift_edge |=> $stable(o_shift_word);
    endproperty
    a_stray: assert property (p_stray) else $error("Stray shift.");

    // Every shift moves the word up one place and takes the new bit at the bottom.
    property p_shift;
        @(posedge i_clock) disable iff (!i_reset_n)
        shift_edge |=> o_shift_word == {$past(o_shift_word[10:0]), $past(data_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("Shift did not advance.");

    // Select high on two samples in a row means no edge of either kind.
    property p_idle;
        @(posedge i_clock) disable iff (!i_reset_n)
        (sel_n_s && select_n_prev) |=> $stable(o_shift_word);
    endproperty
    a_idle: assert property (p_idle) else $error("Shift while deselected.");

    // Raising select while the shift clock is high must not add a bit.
    property p_late_sel;
        @(posedge i_clock) disable iff (!i_reset_n)
        (sel_rise && sclk_s) |=> $stable(o_shift_word);
    endproperty
    a_late_sel: assert property (p_late_sel) else $error("Extra select shift.");

    // Clear low or strobe low refuses every shift.
    property p_refused;
        @(posedge i_clock) disable iff (!i_reset_n)
        (!clear_n_s || !load_n_s) |=> $stable(o_shift_word);
    endproperty
    a_refused: assert property (p_refused) else $error("Shift while refused.");

    // A select rising edge with the shift clock parked low counts as a clock.
    property p_select_edge;
        @(posedge i_clock) disable iff (!i_reset_n)
        (sel_rise && !sclk_s && !shift_clock_prev && gate_ok)
            |=> o_shift_word[0] == $past(data_s);
    endproperty
    a_select_edge: assert property (p_select_edge) else $error("Select edge lost.");

    // The falling edge of the strobe copies the serial word while deselected.
    property p_load;
        @(posedge i_clock) disable iff (!i_reset_n)
        (load_fall && sel_n_s && clear_n_s) |=> o_code == $past(o_shift_word);
    endproperty
    a_load: assert property (p_load) else $error("Load did not copy.");

    // Once the strobe has been low a sample, the code follows the serial word.
    property p_transparent;
        @(posedge i_clock) disable iff (!i_reset_n)
        (!load_n_s && !load_fall && clear_n_s) |=> o_code == $past(o_shift_word);
    endproperty
    a_transparent: assert property (p_transparent) else $error("Code not transparent.");

    // With the strobe and clear high the converter register only holds.
    property p_hold;
        @(posedge i_clock) disable iff (!i_reset_n)
        (load_n_s && clear_n_s) |=> o_code == $past(o_code);
    endproperty
    a_hold: assert property (p_hold) else $error("Code changed while latched.");

    // Clear low forces zero regardless of anything else.
    property p_clear;
        @(posedge i_clock) disable iff (!i_reset_n)
        !clear_n_s |=> o_code == sdlc_pkg::CODE_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not zero.");

    // Clear released with the strobe high keeps the zeros in place.
    property p_clear_release;
        @(posedge i_clock) disable iff (!i_reset_n)
        ($past(!clear_n_s) && clear_n_s && load_n_s) |=> o_code == sdlc_pkg::CODE_ZERO;
    endproperty
    a_clear_release: assert property (p_clear_release) else $error("Zero not kept.");

    // Clear beats a low strobe, so a stale word cannot leak out.
    property p_clear_wins;
        @(posedge i_clock) disable iff (!i_reset_n)
        (!clear_n_s && !load_n_s) |=> o_code == sdlc_pkg::CODE_ZERO;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("Load beat clear.");

    // Shifting a new word in never disturbs the applied code.
    property p_preload;
        @(posedge i_clock) disable iff (!i_reset_n)
        (shift_edge && load_n_s) |=> o_code == $past(o_code);
    endproperty
    a_preload: assert property (p_preload) else $error("Preload moved code.");

    // Main scenarios: shift, select edge, load, follow and clear.
    c_shift: cover property (@(posedge i_clock) disable iff (!i_reset_n) shift_edge);
    c_load:  cover property (@(posedge i_clock) disable iff (!i_reset_n) load_fall && sel_n_s);
    c_clear: cover property (@(posedge i_clock) disable iff (!i_reset_n) !clear_n_s);
    c_select: cover property (@(posedge i_clock) disable iff (!i_reset_n) sel_rise && shift_edge);
    c_follow: cover property (@(posedge i_clock) disable iff (!i_reset_n) !load_n_s && clear_n_s);
endmodule // sdlc_top

// File: verilog/sdlc_pkg.sv
/*
 * Shared constants for the serial converter load control block.
 * Assumes a single system clock at 50 MHz; all link pins are asynchronous to it.
 */
package sdlc_pkg;
    localparam int          CODE_WIDTH   = 12;
    localparam logic [11:0] CODE_RESET   = 12'h000;
    localparam logic [11:0] CODE_ZERO    = 12'h000;
    localparam int          SYNC_STAGES  = 2;
    localparam logic [2:0]  PIN_RESET    = 3'h7;
    localparam logic [1:0]  CTRL_RESET   = 2'h3;
    localparam int          CLOCK_NS     = 20;
endpackage

// File: verilog/sdlc_sync.sv
/*
 * Two-stage synchroniser for a group of asynchronous pins.
 * Assumes the pins change slower than the sampling clock.
 */
`timescale 1ns/1ps
module sdlc_sync #(
    parameter int          WIDTH      = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset.
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    // Pins in, synchronised levels out.
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage_one;

    // The first stage feeds only the second, so metastability never reaches logic.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage_one <= RESET_VALUE;
            o_sync    <= RESET_VALUE;
        end else begin
            stage_one <= i_async;
            o_sync    <= stage_one;
        end
    end
endmodule // sdlc_sync

// File: tb/sdlc_host_model.sv
/* Host model that drives the serial link pins of the converter front end.
   Assumes the 50 MHz bench clock; bits are 160 ns long, pins change on its rising edge. */
`timescale 1ns/1ps
module sdlc_host_model (
    // Bench clock.
    input  wire logic i_clock,
    // Link pins.
    output logic      o_shift_clock,
    output logic      o_serial_data_in,
    output logic      o_select_n
);
    // The link sits idle with its clock parked low and the device deselected.
    initial begin
        o_shift_clock = 1'b0;
        o_serial_data_in = 1'b1;
        o_select_n = 1'b1;
    end
    // Sends the low n bits of w, top bit first; hold_sel keeps select high throughout.
    task automatic send(input logic [15:0] w, input int n, input logic hold_sel);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_clock);
            o_select_n <= hold_sel;
            o_serial_data_in <= w[i];
            o_shift_clock <= 1'b0;
            repeat (4) @(posedge i_clock);
            o_shift_clock <= 1'b1;
            repeat (3) @(posedge i_clock);
        end
        // Deselect while the clock is high, so the select edge cannot shift a bit.
        @(posedge i_clock);
        o_select_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        o_shift_clock <= 1'b0;
        o_serial_data_in <= ~o_serial_data_in;
    endtask
    // Shifts one bit with a select rising edge while the shift clock is low.
    task automatic select_edge(input logic b);
        @(posedge i_clock);
        o_select_n <= 1'b0;
        o_serial_data_in <= b;
        repeat (4) @(posedge i_clock);
        o_select_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        o_serial_data_in <= ~b;
    endtask
endmodule // sdlc_host_model

// File: tb/sdlc_top_tb.sv
/* Self-checking bench for the converter load control block.
   Assumes the host model owns the link pins; the bench owns reset, strobe and clear. */
`timescale 1ns/1ps
module sdlc_top_tb;
    typedef struct {logic [15:0] w; int n; logic [11:0] e;} sdlc_row_type;
    logic        i_clock, i_reset_n, i_load_strobe_n, i_clear_n;
    logic        sck, sdi, sel_n;
    logic [11:0] o_code, o_shift_word, prev;
    int          num_errors = 0;
    int          n_compared = 0;
    sdlc_row_type rows [4] = '{'{16'h0a5c, 12, 12'ha5c}, '{16'h1000, 13, 12'h000},
                               '{16'hbeef, 16, 12'heef}, '{16'h0fff, 12, 12'hfff}};
    sdlc_top u_sdlc_top (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_shift_clock(sck),
        .i_serial_data_in(sdi), .i_select_n(sel_n), .i_load_strobe_n(i_load_strobe_n),
        .i_clear_n(i_clear_n), .o_code(o_code), .o_shift_word(o_shift_word));
    sdlc_host_model u_sdlc_host_model (.i_clock(i_clock), .o_shift_clock(sck),
        .o_serial_data_in(sdi), .o_select_n(sel_n));
    // Compares and counts; an unknown never matches.
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Sets strobe and clear, then waits past the two-clock synchroniser delay.
    task automatic pins(input logic strobe_n, input logic zero_n);
        @(posedge i_clock);
        i_load_strobe_n <= strobe_n;
        i_clear_n <= zero_n;
        repeat (6) @(posedge i_clock);
    endtask
    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Free-running 50 MHz clock.
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // Watchdog: the tests need well under a thousand bit times.
    initial begin
        repeat (20000) @(posedge i_clock);
        num_errors++;
        report_and_stop();
    end
    // Table rows, then the awkward cases by hand.
    initial begin
        i_reset_n = 1'b0;
        i_load_strobe_n = 1'b1;
        i_clear_n = 1'b1;
        prev = 12'h000;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'b1;
        pins(1'b1, 1'b1);
        check(o_code, 12'h000);
        foreach (rows[k]) begin
            u_sdlc_host_model.send(rows[k].w, rows[k].n, 1'b0);
            pins(1'b1, 1'b1);
            check(o_shift_word, rows[k].e);
            check(o_code, prev);
            pins(1'b0, 1'b1);
            pins(1'b1, 1'b1);
            check(o_code, rows[k].e);
            prev = rows[k].e;
            $display("Row %0d done", k);
        end
        u_sdlc_host_model.send(16'h0000, 12, 1'b1);
        pins(1'b1, 1'b1);
        check(o_shift_word, 12'hfff);
        $display("Deselected clocking done");
        u_sdlc_host_model.select_edge(1'b0);
        pins(1'b1, 1'b1);
        check(o_shift_word, 12'hffe);
        $display("Select edge done");
        pins(1'b0, 1'b0);
        check(o_code, 12'h000);
        $display("Clear priority done");
        pins(1'b0, 1'b1);
        check(o_code, 12'hffe);
        $display("Transparency done");
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        check(o_code, 12'h000);
        $display("Clear release done");
        // A fresh code in both registers makes the mid-run reset visible.
        u_sdlc_host_model.send(16'h0123, 12, 1'b0);
        check(o_shift_word, 12'h123);
        check(o_code, 12'h000);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        check(o_code, 12'h123);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        check(o_shift_word, 12'h000);
        check(o_code, 12'h000);
        i_reset_n <= 1'b1;
        pins(1'b1, 1'b1);
        check(o_shift_word, 12'h000);
        check(o_code, 12'h000);
        $display("Mid-run reset done");
        report_and_stop();
    end
endmodule // sdlc_top_tb
